// File: hdl/mcl_core_exec.sv
// mcl_core_exec.sv: execution of load, multiply, not, or, backdoor read,
// software interrupt, subroutine return and register reset for one microcore
// assumes instructions arrive synchronous to core_clk_i with valid/ready
`timescale 1ns/1ps
`default_nettype none
module mcl_core_exec
  import mcl_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // instruction fetch
  input  wire logic [15:0] instr_i,
  input  wire logic        instr_valid_i,
  output logic             instr_ready_o,
  output logic      [9:0]  pc_o,
  // subroutine call and interrupts
  input  wire logic        call_i,
  input  wire logic [9:0]  call_target_i,
  input  wire logic        hw_irq_i,
  input  wire logic [9:0]  irq_vector_i,
  input  wire logic        irq_exit_i,
  output logic             soft_irq_o,
  output logic      [1:0]  soft_irq_id_o,
  output logic             soft_irq_active_o,
  output logic      [15:0] irq_status_o,
  output logic      [9:0]  irq_return_o,
  // data ram write side and index base
  input  wire logic        dram_wr_en_i,
  input  wire logic [5:0]  dram_wr_addr_i,
  input  wire logic [15:0] dram_wr_data_i,
  input  wire logic [5:0]  base_addr_i,
  // register space backdoor
  input  wire logic [15:0] spi_addr_i,
  input  wire logic        spi_addr_wr_i,
  input  wire logic [15:0] spi_rd_data_i,
  output logic             spi_rd_req_o,
  output logic      [15:0] spi_rd_addr_o,
  output logic      [15:0] spi_rd_result_o,
  output logic             spi_rd_fail_o,
  // register reset strobes
  output logic             clear_status_o,
  output logic             clear_control_o,
  output logic             clear_diag_o,
  output logic             diag_rearm_o,
  // results and flags
  output logic      [15:0] product_high_half_o,
  output logic      [15:0] product_low_half_o,
  output logic             multiply_overflow_flag_o,
  output logic             precision_loss_flag_o,
  output logic             operation_complete_flag_o,
  output logic             zero_mask_flag_o,
  output logic             all_ones_flag_o,
  output logic [7:0][15:0] core_regs_o
);
  // ==========================================================
  // helpers
  function automatic logic op_match(input logic [15:0] ins,
                                    input logic [15:0] val,
                                    input logic [15:0] msk);
    op_match = ((ins & msk) == val);
  endfunction

  function automatic logic is_zero(input logic [15:0] v);
    is_zero = (v == `MCL_ZERO16);
  endfunction

  function automatic logic is_ones(input logic [15:0] v);
    is_ones = (v == `MCL_ONES16);
  endfunction

  // ==========================================================
  // state and sub-blocks
  mcl_core_t   s_reg;
  mcl_core_t   s_next;
  logic        take;
  logic        irq_take;
  logic        dec_load;
  logic        dec_mul;
  logic        dec_muli;
  logic        dec_not;
  logic        dec_or;
  logic        dec_rdspi;
  logic        dec_reqi;
  logic        dec_rfs;
  logic        dec_rstreg;
  logic [5:0]  ram_addr;
  logic        ram_rd;
  logic [15:0] ram_data;
  logic        mul_start;
  logic [15:0] mul_a;
  logic [15:0] mul_b;
  logic        mul_busy;
  logic [31:0] mul_product;
  logic [2:0]  op1_idx;
  logic [2:0]  op2_idx;
  logic [15:0] alu_res;

  assign op1_idx  = instr_i[2:0];
  assign op2_idx  = instr_i[`MCL_DST_HI:`MCL_DST_LO];

  assign dec_load   = op_match(instr_i, `MCL_LOAD_VAL, `MCL_LOAD_MSK);
  assign dec_mul    = op_match(instr_i, `MCL_MUL_VAL, `MCL_MUL_MSK);
  assign dec_muli   = op_match(instr_i, `MCL_MULI_VAL, `MCL_MULI_MSK);
  assign dec_not    = op_match(instr_i, `MCL_NOT_VAL, `MCL_OP3_MSK);
  assign dec_or     = op_match(instr_i, `MCL_OR_VAL, `MCL_OP3_MSK);
  assign dec_rdspi  = op_match(instr_i, `MCL_RDSPI_VAL, `MCL_FULL_MSK);
  assign dec_reqi   = op_match(instr_i, `MCL_REQI_VAL, `MCL_REQI_MSK);
  assign dec_rfs    = op_match(instr_i, `MCL_RFS_VAL, `MCL_FULL_MSK);
  assign dec_rstreg = op_match(instr_i, `MCL_RSTREG_VAL, `MCL_OP3_MSK);

  // interrupts preempt fetch, but never a running software interrupt
  assign irq_take = (s_reg.st == ST_RUN) && hw_irq_i && !s_reg.soft_active;
  assign instr_ready_o = ce_i && (s_reg.st == ST_RUN) && !irq_take && !call_i && !irq_exit_i;
  assign take          = instr_ready_o && instr_valid_i;

  // index mode wraps inside the 64-word ram
  assign ram_addr = instr_i[`MCL_OFS_BIT] ?
                    6'(base_addr_i + instr_i[`MCL_DRAM_HI:`MCL_DRAM_LO]) :
                    instr_i[`MCL_DRAM_HI:`MCL_DRAM_LO];
  assign ram_rd   = take && dec_load;

  assign mul_start = take && (dec_mul || dec_muli);
  assign mul_a     = s_reg.regs[op1_idx];
  assign mul_b     = dec_muli ? {12'h000, instr_i[`MCL_IMM_HI:`MCL_IMM_LO]} :
                     s_reg.regs[op2_idx];

  always_comb begin
    alu_res = ~s_reg.regs[op1_idx];
    if (dec_or) begin
      alu_res = s_reg.regs[op1_idx] | s_reg.regs[`MCL_IMM_REG_IDX];
    end
  end

  mcl_dram u_dram (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .wr_en_i    (dram_wr_en_i),
    .wr_addr_i  (dram_wr_addr_i),
    .wr_data_i  (dram_wr_data_i),
    .rd_en_i    (ram_rd),
    .rd_addr_i  (ram_addr),
    .rd_data_o  (ram_data)
  );

  mcl_mul u_mul (
    .core_clk_i       (core_clk_i),
    .rst_i            (rst_i),
    .ce_i             (ce_i),
    .start_i          (mul_start),
    .a_i              (mul_a),
    .b_i              (mul_b),
    .busy_o           (mul_busy),
    .product_o        (mul_product),
    .overflow_o       (multiply_overflow_flag_o),
    .precision_loss_o (precision_loss_flag_o),
    .complete_o       (operation_complete_flag_o)
  );

  // ==========================================================
  // sequencer
  always_comb begin
    s_next             = s_reg;
    s_next.rd_req      = 1'b0;
    s_next.soft_pulse  = 1'b0;
    s_next.clr_status  = 1'b0;
    s_next.clr_control = 1'b0;
    s_next.clr_diag    = 1'b0;
    s_next.rearm       = 1'b0;
    // a change after the read was issued spoils its data
    if (s_reg.rd_watch && spi_addr_wr_i) begin
      s_next.rd_data = `MCL_DUMMY16;
      s_next.rd_fail = 1'b1;
    end
    case (s_reg.st)
      ST_RUN: begin
        if (irq_take) begin
          s_next.ret             = s_reg.pc;
          s_next.irq_status[9:0] = s_reg.pc;
          s_next.pc              = irq_vector_i;
        end else if (irq_exit_i) begin
          s_next.pc          = s_reg.ret;
          s_next.soft_active = 1'b0;
        end else if (call_i) begin
          s_next.aux = 10'(s_reg.pc + 10'h001);
          s_next.pc  = call_target_i;
        end else if (take) begin
          s_next.rd_watch = 1'b0;
          s_next.pc       = 10'(s_reg.pc + 10'h001);
          if (dec_load) begin
            s_next.dst = instr_i[`MCL_DST_HI:`MCL_DST_LO];
            s_next.st  = ST_LOAD;
          end else if (dec_mul || dec_muli) begin
            s_next.st = ST_MUL;
          end else if (dec_not || dec_or) begin
            s_next.regs[op1_idx] = alu_res;
            s_next.zero_flag     = is_zero(alu_res);
            s_next.ones_flag     = is_ones(alu_res);
          end else if (dec_rdspi) begin
            s_next.rd_addr = spi_addr_i;
            s_next.rd_req  = 1'b1;
            s_next.rd_fail = 1'b0;
            s_next.st      = ST_RDSPI;
          end else if (dec_reqi) begin
            s_next.irq_status[9:0] = s_reg.pc;
            s_next.ret             = 10'(s_reg.pc + 10'h001);
            s_next.soft_id         = instr_i[1:0];
            s_next.soft_pulse      = 1'b1;
            s_next.soft_active     = 1'b1;
            s_next.pc              = irq_vector_i;
          end else if (dec_rfs) begin
            s_next.pc = s_reg.aux;
          end else if (dec_rstreg) begin
            case (instr_i[2:0])
              3'b000: begin
                s_next.clr_status = 1'b1;
              end
              3'b001: begin
                s_next.clr_control = 1'b1;
              end
              3'b010: begin
                s_next.clr_status = 1'b1;
                s_next.clr_diag   = 1'b1;
                s_next.rearm      = 1'b1;
              end
              3'b011: begin
                s_next.clr_status  = 1'b1;
                s_next.clr_control = 1'b1;
                s_next.clr_diag    = 1'b1;
                s_next.rearm       = 1'b1;
              end
              3'b100: begin
                s_next.clr_diag = 1'b1;
                s_next.rearm    = 1'b1;
              end
              3'b101: begin
                s_next.clr_status  = 1'b1;
                s_next.clr_control = 1'b1;
              end
              3'b110: begin
                s_next.clr_status = 1'b1;
                s_next.rearm      = 1'b1;
              end
              default: begin
                s_next.rearm = 1'b1;
              end
            endcase
          end
        end
      end
      ST_LOAD: begin
        s_next.regs[s_reg.dst] = ram_data;
        s_next.st              = ST_RUN;
      end
      ST_MUL: begin
        // mul_busy rises the cycle after start, so wait on its fall
        if (!mul_busy && !mul_start) begin
          s_next.st = ST_RUN;
        end
      end
      ST_RDSPI: begin
        s_next.rd_data  = spi_rd_data_i;
        s_next.rd_watch = 1'b1;
        s_next.st       = ST_RUN;
        if (spi_addr_wr_i) begin
          s_next.rd_data = `MCL_DUMMY16;
          s_next.rd_fail = 1'b1;
        end
      end
      default: begin
        s_next.st = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_reg    <= '0;
      s_reg.pc <= `MCL_PC_RESET;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // outputs
  assign pc_o                = s_reg.pc;
  assign soft_irq_o          = s_reg.soft_pulse;
  assign soft_irq_id_o       = s_reg.soft_id;
  assign soft_irq_active_o   = s_reg.soft_active;
  assign irq_status_o        = s_reg.irq_status;
  assign irq_return_o        = s_reg.ret;
  assign spi_rd_req_o        = s_reg.rd_req;
  assign spi_rd_addr_o       = s_reg.rd_addr;
  assign spi_rd_result_o     = s_reg.rd_data;
  assign spi_rd_fail_o       = s_reg.rd_fail;
  assign clear_status_o      = s_reg.clr_status;
  assign clear_control_o     = s_reg.clr_control;
  assign clear_diag_o        = s_reg.clr_diag;
  assign diag_rearm_o        = s_reg.rearm;
  assign product_high_half_o = mul_product[31:16];
  assign product_low_half_o  = mul_product[15:0];
  assign zero_mask_flag_o    = s_reg.zero_flag;
  assign all_ones_flag_o     = s_reg.ones_flag;
  assign core_regs_o         = s_reg.regs;
endmodule
`default_nettype wire

// File: hdl/mcl_cfg.svh
// mcl_cfg.svh: opcodes, masks, field positions, reset values and counts
// assumes inclusion by bare name from the package and the modules
`ifndef MCL_CFG_SVH
`define MCL_CFG_SVH
// ============================================================
// opcode values and masks
`define MCL_LOAD_VAL    16'h8002
`define MCL_LOAD_MSK    16'hC003
`define MCL_MUL_VAL     16'h2D80
`define MCL_MUL_MSK     16'hFFC0
`define MCL_MULI_VAL    16'h2700
`define MCL_MULI_MSK    16'hFF80
`define MCL_NOT_VAL     16'h2ED8
`define MCL_OR_VAL      16'h2EC0
`define MCL_RSTREG_VAL  16'h3548
`define MCL_OP3_MSK     16'hFFF8
`define MCL_RDSPI_VAL   16'h3540
`define MCL_RFS_VAL     16'h359C
`define MCL_FULL_MSK    16'hFFFF
`define MCL_REQI_VAL    16'h3588
`define MCL_REQI_MSK    16'hFFFC
// ============================================================
// field positions
`define MCL_DRAM_HI     13
`define MCL_DRAM_LO     8
`define MCL_DST_HI      5
`define MCL_DST_LO      3
`define MCL_OFS_BIT     2
`define MCL_IMM_HI      6
`define MCL_IMM_LO      3
// ============================================================
// register space offsets
`define MCL_CORE0_CTRL_A  12'h101
`define MCL_CORE0_CTRL_B  12'h102
`define MCL_CORE0_STAT_A  12'h105
`define MCL_CORE0_STAT_B  12'h106
`define MCL_CORE0_IRQ     12'h10F
`define MCL_CORE1_CTRL_A  12'h121
`define MCL_CORE1_CTRL_B  12'h122
`define MCL_CORE1_STAT_A  12'h125
`define MCL_CORE1_STAT_B  12'h126
`define MCL_CORE1_IRQ     12'h12F
`define MCL_DIAG_FIRST    12'h162
`define MCL_DIAG_LAST     12'h169
// ============================================================
// reset values, indices and timing
`define MCL_ZERO16      16'h0000
`define MCL_ONES16      16'hFFFF
`define MCL_DUMMY16     16'hDEAD
`define MCL_PC_RESET    10'h000
`define MCL_IMM_REG_IDX 3'h7
`define MCL_MUL_STEPS   5'h10
`define MCL_MUL_CYCLES  17
`endif

// File: hdl/mcl_pkg.sv
// mcl_pkg.sv: state enum and packed state records of the microcore slice
// assumes mcl_cfg.svh on the include path
`default_nettype none
`include "mcl_cfg.svh"
package mcl_pkg;
  // ==========================================================
  // main sequencer
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_LOAD  = 2'b01,
    ST_MUL   = 2'b10,
    ST_RDSPI = 2'b11
  } mcl_state_t;

  typedef struct packed {
    mcl_state_t        st;
    logic [9:0]        pc;
    logic [9:0]        aux;
    logic [9:0]        ret;
    logic [15:0]       irq_status;
    logic              soft_active;
    logic [7:0][15:0]  regs;
    logic [2:0]        dst;
    logic [15:0]       rd_addr;
    logic [15:0]       rd_data;
    logic              rd_req;
    logic              rd_watch;
    logic              rd_fail;
    logic              zero_flag;
    logic              ones_flag;
    logic              soft_pulse;
    logic [1:0]        soft_id;
    logic              clr_status;
    logic              clr_control;
    logic              clr_diag;
    logic              rearm;
  } mcl_core_t;

  // ==========================================================
  // multiplier and memory
  typedef struct packed {
    logic              busy;
    logic [4:0]        cnt;
    logic [15:0]       a;
    logic [15:0]       b;
    logic [31:0]       acc;
    logic [31:0]       product;
    logic              overflow;
    logic              precision_loss;
    logic              complete;
  } mcl_mul_t;

  typedef struct packed {
    logic [63:0][15:0] mem;
    logic [15:0]       rd_data;
  } mcl_dram_t;
endpackage
`default_nettype wire

// File: hdl/mcl_dram.sv
// mcl_dram.sv: 64-word data ram, one write and one registered read port
// assumes a single clock; write and read in one cycle give the old word
`timescale 1ns/1ps
`default_nettype none
module mcl_dram
  import mcl_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wr_en_i,
  input  wire logic [5:0]  wr_addr_i,
  input  wire logic [15:0] wr_data_i,
  input  wire logic        rd_en_i,
  input  wire logic [5:0]  rd_addr_i,
  output logic      [15:0] rd_data_o
);
  mcl_dram_t s_reg;
  mcl_dram_t s_next;

  always_comb begin
    s_next = s_reg;
    if (rd_en_i) begin
      s_next.rd_data = s_reg.mem[rd_addr_i];
    end
    if (wr_en_i) begin
      s_next.mem[wr_addr_i] = wr_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  assign rd_data_o = s_reg.rd_data;
endmodule
`default_nettype wire

// File: hdl/mcl_mul.sv
// mcl_mul.sv: 16 x 16 shift-add multiplier, product ready 17 cycles after start
// assumes start only while not busy
`timescale 1ns/1ps
`default_nettype none
module mcl_mul
  import mcl_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        start_i,
  input  wire logic [15:0] a_i,
  input  wire logic [15:0] b_i,
  output logic             busy_o,
  output logic      [31:0] product_o,
  output logic             overflow_o,
  output logic             precision_loss_o,
  output logic             complete_o
);
  mcl_mul_t s_reg;
  mcl_mul_t s_next;

  always_comb begin
    s_next = s_reg;
    if (start_i && !s_reg.busy) begin
      s_next.busy     = 1'b1;
      s_next.cnt      = 5'h00;
      s_next.a        = a_i;
      s_next.b        = b_i;
      s_next.acc      = '0;
      s_next.complete = 1'b0;
    end else if (s_reg.busy) begin
      if (s_reg.cnt == `MCL_MUL_STEPS) begin
        // last cycle only commits, so product lands on cycle 17
        s_next.busy           = 1'b0;
        s_next.product        = s_reg.acc;
        s_next.overflow       = (s_reg.acc[31:16] != `MCL_ZERO16);
        s_next.precision_loss = (s_reg.acc[31:16] != `MCL_ZERO16) &&
                                (s_reg.acc[15:0] != `MCL_ZERO16);
        s_next.complete       = 1'b1;
      end else begin
        if (s_reg.b[s_reg.cnt[3:0]]) begin
          s_next.acc = s_reg.acc + ({16'h0000, s_reg.a} << s_reg.cnt[3:0]);
        end
        s_next.cnt = s_reg.cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  assign busy_o           = s_reg.busy;
  assign product_o        = s_reg.product;
  assign overflow_o       = s_reg.overflow;
  assign precision_loss_o = s_reg.precision_loss;
  assign complete_o       = s_reg.complete;
endmodule
`default_nettype wire

// File: testbench/mcl_core_exec_sva.sv
// mcl_core_exec_sva.sv: port assertions for the execution slice
// assumes one core clock, sync high reset, bound into mcl_core_exec
`timescale 1ns/1ps
`default_nettype none
`include "mcl_cfg.svh"
module mcl_core_exec_sva
  import mcl_pkg::*;
(
  input wire logic             core_clk_i,
  input wire logic             rst_i,
  input wire logic             ce_i,
  input wire logic [15:0]      instr_i,
  input wire logic             instr_valid_i,
  input wire logic             instr_ready_o,
  input wire logic [9:0]       pc_o,
  input wire logic             hw_irq_i,
  input wire logic             irq_exit_i,
  input wire logic             soft_irq_o,
  input wire logic [1:0]       soft_irq_id_o,
  input wire logic             soft_irq_active_o,
  input wire logic [15:0]      irq_status_o,
  input wire logic [9:0]       irq_return_o,
  input wire logic [15:0]      spi_addr_i,
  input wire logic             spi_addr_wr_i,
  input wire logic             spi_rd_req_o,
  input wire logic [15:0]      spi_rd_addr_o,
  input wire logic [15:0]      spi_rd_result_o,
  input wire logic             spi_rd_fail_o,
  input wire logic             clear_status_o,
  input wire logic             clear_control_o,
  input wire logic             clear_diag_o,
  input wire logic             diag_rearm_o,
  input wire logic [15:0]      product_high_half_o,
  input wire logic [15:0]      product_low_half_o,
  input wire logic             multiply_overflow_flag_o,
  input wire logic             precision_loss_flag_o,
  input wire logic             operation_complete_flag_o,
  input wire logic             zero_mask_flag_o,
  input wire logic             all_ones_flag_o,
  input wire logic [7:0][15:0] core_regs_o
);
  // ==========================================================
  // taken instructions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  localparam logic [31:0] CLR_TBL = 32'h19C3_FB48;
  logic take;
  assign take = instr_valid_i & instr_ready_o & ce_i;
  sequence s_op(logic [15:0] m, logic [15:0] v);
    take && ((instr_i & m) == v);
  endsequence
  sequence s_mul;
    s_op(`MCL_MUL_MSK, `MCL_MUL_VAL) or s_op(`MCL_MULI_MSK, `MCL_MULI_VAL);
  endsequence
  sequence s_mask;
    s_op(`MCL_OP3_MSK, `MCL_NOT_VAL) or s_op(`MCL_OP3_MSK, `MCL_OR_VAL);
  endsequence
  // ==========================================================
  // assertions
  a_load_stall: assert property (s_op(`MCL_LOAD_MSK, `MCL_LOAD_VAL) |=> !instr_ready_o)
    else $error("fetch not stalled after load");
  a_mul_latency: assert property (s_mul |=> !operation_complete_flag_o [*8]
    ##1 !operation_complete_flag_o [*8]
    ##1 !operation_complete_flag_o ##1 operation_complete_flag_o)
    else $error("multiply completion not at cycle 17");
  a_mul_flags: assert property ($rose(operation_complete_flag_o) |->
    multiply_overflow_flag_o == (product_high_half_o != 16'h0000) && precision_loss_flag_o ==
    (product_high_half_o != 16'h0000 && product_low_half_o != 16'h0000))
    else $error("multiply flags wrong");
  a_mask_flags: assert property (s_mask |=>
    zero_mask_flag_o == (core_regs_o[$past(instr_i[2:0])] == 16'h0000) &&
    all_ones_flag_o == (core_regs_o[$past(instr_i[2:0])] == 16'hFFFF))
    else $error("mask flags wrong");
  a_rd_request: assert property (s_op(`MCL_FULL_MSK, `MCL_RDSPI_VAL) |=>
    spi_rd_req_o && spi_rd_addr_o == $past(spi_addr_i))
    else $error("backdoor request wrong");
  a_rd_abandon: assert property (spi_rd_req_o && spi_addr_wr_i |=>
    spi_rd_fail_o && spi_rd_result_o == `MCL_DUMMY16)
    else $error("abandoned read not flagged");
  a_soft_entry: assert property (s_op(`MCL_REQI_MSK, `MCL_REQI_VAL) |=>
    soft_irq_o && soft_irq_active_o && soft_irq_id_o == $past(instr_i[1:0]) &&
    irq_status_o[9:0] == $past(pc_o) && irq_return_o == $past(pc_o) + 10'h001)
    else $error("software interrupt entry wrong");
  a_soft_shield: assert property (soft_irq_active_o && hw_irq_i && !irq_exit_i && !take |=>
    $stable(irq_status_o) && $stable(irq_return_o))
    else $error("software interrupt was interrupted");
  a_reg_clear: assert property (s_op(`MCL_OP3_MSK, `MCL_RSTREG_VAL) |=>
    {clear_status_o, clear_control_o, clear_diag_o, diag_rearm_o} ==
    4'(CLR_TBL >> {$past(instr_i[2:0]), 2'b00}))
    else $error("register clear strobes wrong");
endmodule
bind mcl_core_exec mcl_core_exec_sva u_sva (.*);
`default_nettype wire

// File: testbench/mcl_regspace_model.sv
// mcl_regspace_model.sv: register space behind the backdoor read path
// assumes a request pulse, data sampled in the cycle that it is high
`timescale 1ns/1ps
`default_nettype none
module mcl_regspace_model #(
  parameter logic [15:0] KEY = 16'hA5C3
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        rd_req_i,
  input  wire logic [15:0] rd_addr_i,
  output logic      [15:0] rd_data_o
);
  logic [15:0] junk_reg;
  // moving junk outside a request so a stale sample never matches
  always_ff @(posedge core_clk_i) junk_reg <= rst_i ? 16'h0F0F : ~junk_reg ^ 16'h0101;
  assign rd_data_o = rd_req_i ? (rd_addr_i ^ KEY) : junk_reg;
endmodule
`default_nettype wire

// File: testbench/mcl_core_exec_tb.sv
// mcl_core_exec_tb.sv: self-checking bench for the execution slice
// assumes the register space model on the backdoor, 40 MHz core clock
`timescale 1ns/1ps
`default_nettype none
`include "mcl_cfg.svh"
module mcl_core_exec_tb;
  import mcl_pkg::*;
  localparam logic [15:0] KEY = 16'hA5C3;
  localparam logic [31:0] CLR_TBL = 32'h19C3_FB48;
  logic core_clk_i = '0, rst_i = '1, ce_i = '1, instr_valid_i = '0, call_i = '0;
  logic hw_irq_i = '0, irq_exit_i = '0, dram_wr_en_i = '0, spi_addr_wr_i = '0;
  logic [15:0] instr_i = '0, dram_wr_data_i = '0, spi_addr_i = '0, spi_rd_data_i;
  logic [9:0] call_target_i = '0, irq_vector_i = 10'h3C0, pc_o, irq_return_o;
  logic [5:0] dram_wr_addr_i = '0, base_addr_i = 6'h3C;
  logic instr_ready_o, soft_irq_o, soft_irq_active_o, spi_rd_req_o, spi_rd_fail_o;
  logic clear_status_o, clear_control_o, clear_diag_o, diag_rearm_o, zero_mask_flag_o;
  logic multiply_overflow_flag_o, precision_loss_flag_o, operation_complete_flag_o;
  logic all_ones_flag_o, prev_cmp = '0, prev_req = '0;
  logic [1:0] soft_irq_id_o;
  logic [15:0] irq_status_o, spi_rd_addr_o, spi_rd_result_o, a, b;
  logic [15:0] product_high_half_o, product_low_half_o;
  logic [7:0][15:0] core_regs_o;
  logic [31:0] seed = 32'h3d0c_9334;
  logic [31:0] notes[$];
  logic [9:0] pc0;
  int failures = 0, compares = 0, cycles = 0;

  always #12.5 core_clk_i = ~core_clk_i;
  mcl_core_exec DUT (.*);
  mcl_regspace_model #(.KEY(KEY)) u_regs (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .rd_req_i(spi_rd_req_o), .rd_addr_i(spi_rd_addr_o), .rd_data_o(spi_rd_data_i));

  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic give_verdict;
    $display("TB: %0d mismatches in %0d comparisons", failures, compares);
    if (failures == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  task automatic settle;
    int n;
    n = 0;
    while (instr_ready_o !== 1'b1 && n < 50) begin tick(1); n++; end
  endtask
  // leading tick keeps valid from toggling twice in one step
  task automatic exec(input logic [15:0] w);
    tick(1);
    instr_i = w;
    instr_valid_i = 1'b1;
    settle;
    tick(1);
    instr_valid_i = 1'b0;
  endtask
  task automatic load(input logic [5:0] ad, input logic [2:0] r, input logic ofs,
                      input logic [15:0] d);
    dram_wr_en_i = 1'b1;
    dram_wr_addr_i = ad + (ofs ? base_addr_i : 6'h00);
    dram_wr_data_i = d;
    tick(1);
    dram_wr_en_i = 1'b0;
    exec(`MCL_LOAD_VAL | {2'b00, ad, 2'b00, r, ofs, 2'b00});
    settle;
    check("load", 32'(core_regs_o[r]), 32'(d));
  endtask

  // ==========================================================
  // result watcher and hang limit
  always @(negedge core_clk_i) begin
    cycles++;
    if (cycles > 4000) begin failures++; give_verdict; end
    if (!rst_i && operation_complete_flag_o && !prev_cmp && notes.size() > 0)
      check("product", {product_high_half_o, product_low_half_o}, notes.pop_front());
    if (!rst_i && prev_req && !spi_rd_req_o && notes.size() > 0)
      check("backdoor", {15'h0000, spi_rd_fail_o, spi_rd_result_o}, notes.pop_front());
    prev_cmp = operation_complete_flag_o;
    prev_req = spi_rd_req_o;
  end

  // ==========================================================
  // scenarios
  initial begin
    tick(4);
    rst_i = 1'b0;
    seed = lfsr(seed);
    a = seed[15:0];
    seed = lfsr(seed);
    b = seed[31:16];
    load(6'h05, 3'h1, 1'b0, a);
    load(6'h0A, 3'h2, 1'b1, b);
    notes.push_back(32'(a) * 32'(b));
    exec(`MCL_MUL_VAL | 16'h0011);
    notes.push_back(32'(a) * 32'h0000_000F);
    exec(`MCL_MULI_VAL | 16'h0079);
    settle;
    load(6'h10, 3'h3, 1'b0, 16'hFFFF);
    exec(`MCL_NOT_VAL | 16'h0003);
    check("not low", 32'({core_regs_o[3], zero_mask_flag_o, all_ones_flag_o}), 32'h0000_0002);
    exec(`MCL_NOT_VAL | 16'h0003);
    check("not high", 32'({core_regs_o[3], zero_mask_flag_o, all_ones_flag_o}), 32'h0003_FFFD);
    load(6'h11, 3'h7, 1'b0, a);
    exec(`MCL_OR_VAL | 16'h0002);
    check("or", 32'({core_regs_o[2], zero_mask_flag_o, all_ones_flag_o}),
          32'({a | b, (a | b) == 16'h0000, (a | b) == 16'hFFFF}));
    spi_addr_i = 16'(`MCL_CORE0_STAT_A);
    notes.push_back(32'(spi_addr_i ^ KEY));
    exec(`MCL_RDSPI_VAL);
    settle;
    spi_addr_i = 16'(`MCL_DIAG_FIRST);
    notes.push_back({15'h0000, 1'b1, `MCL_DUMMY16});
    exec(`MCL_RDSPI_VAL);
    spi_addr_wr_i = 1'b1;
    tick(1);
    spi_addr_wr_i = 1'b0;
    settle;
    for (int t = 0; t < 8; t++) begin
      exec(`MCL_RSTREG_VAL | 16'(t));
      check("clear", 32'({clear_status_o, clear_control_o, clear_diag_o, diag_rearm_o}),
            32'(CLR_TBL[t*4 +: 4]));
    end
    pc0 = pc_o;
    exec(`MCL_REQI_VAL | 16'h0002);
    check("soft entry", 32'({soft_irq_o, soft_irq_id_o, irq_status_o[9:0], irq_return_o}),
          32'({1'b1, 2'h2, pc0, pc0 + 10'h001}));
    hw_irq_i = 1'b1;
    tick(3);
    check("shielded", 32'({pc_o, irq_status_o[9:0]}), 32'({irq_vector_i, pc0}));
    irq_exit_i = 1'b1;
    tick(1);
    irq_exit_i = 1'b0;
    check("soft return", 32'(pc_o), 32'(pc0 + 10'h001));
    tick(1);
    hw_irq_i = 1'b0;
    check("hw entry", 32'({pc_o, irq_return_o}), 32'({irq_vector_i, pc0 + 10'h001}));
    pc0 = pc_o;
    call_target_i = 10'h200;
    call_i = 1'b1;
    tick(1);
    call_i = 1'b0;
    exec(`MCL_RFS_VAL);
    check("sub return", 32'(pc_o), 32'(pc0 + 10'h001));
    tick(2);
    give_verdict;
  end
endmodule
`default_nettype wire
